//--- motion_task_start_select.sv
// Purpose: start, cancel and select motion tasks and home moves
// Assumes: task selection and configuration inputs are stable
// Notes:   start, stop and home outputs are one-cycle pulses
`timescale 1ns/1ps

// Contract
// - standard start input: rising edge starts task, falling edge cancels it.
// - latched start: rising edge starts program, keeps running when input drops.
// - falling edge on another standard start input stops a latched program.
// - terminal or fieldbus stop command stops a latched program.
// - numbered start with all task-number bits zero performs a home move.
// - dedicated start with all eight task-number inputs low runs home move.
// - auto home on enable set to one homes whenever drive becomes enabled, except in a cycle where the editor halts a running program.
// - opening the graphical editor halts all executing motion tasks.
// - homing method zero sets reference immediately, no movement.
// - task requested before homing is refused with not-homed error.
module motion_task_start_select
	import motion_start_pkg::*;
(
	// clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	// configurable digital inputs
	input  wire logic [NUM_IN-1:0]    din_i,
	input  wire logic [7:0]           din_func_i [NUM_IN],
	input  wire logic [7:0]           din_value_i [NUM_IN],
	// dedicated start and task number inputs
	input  wire logic                 dedicated_task_start_input_i,
	input  wire logic [TASK_BITS-1:0] task_number_bit_i,
	// drive state and configuration
	input  wire logic                 drive_enable_i,
	input  wire logic                 auto_home_on_enable_i,
	input  wire logic [7:0]           home_method_i,
	input  wire logic                 home_done_i,
	// stop sources and editor state
	input  wire logic                 terminal_stop_i,
	input  wire logic                 bus_stop_i,
	input  wire logic                 editor_open_i,
	// motion control outputs
	output logic                      task_start_o,
	output logic [TASK_BITS-1:0]      task_number_o,
	output logic                      task_cancel_o,
	output logic                      home_start_o,
	output logic                      set_ref_now_o,
	output logic                      program_running_o,
	output logic                      homed_o,
	output logic [7:0]                error_code_o
);
	// ----------------------------------------------------------------
	// input conditioning
	// ----------------------------------------------------------------
	localparam int NSRC = NUM_IN + 2;
	logic [NSRC-1:0] lvl;
	logic [NSRC-1:0] rise;
	logic [NSRC-1:0] fall;
	logic [NSRC-1:0] raw;

	assign raw = {drive_enable_i, dedicated_task_start_input_i, din_i};

	// one synchroniser per digital input, dedicated start input and drive enable
	for (genvar g = 0; g < NSRC; g++)
	begin : g_sync
		edge_sync u_sync (
			.mclk_i  (mclk_i),
			.rst_n_i (rst_n_i),
			.raw_i   (raw[g]),
			.level_o (lvl[g]),
			.rise_o  (rise[g]),
			.fall_o  (fall[g])
		);
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                 start;
		logic [TASK_BITS-1:0] number;
		logic                 cancel;
		logic                 home;
		logic                 set_ref;
		logic                 running;
		logic                 homed;
		logic [7:0]           err;
	} ctl_s;

	ctl_s cur;
	ctl_s next_cur;

	// ----------------------------------------------------------------
	// decode of input events
	// ----------------------------------------------------------------
	logic std_rise;
	logic std_fall;
	logic lat_rise;
	logic num_rise;
	logic num_zero;
	logic home_req;
	logic task_req;
	logic stop_any;

	// classify edges by configured function of each input
	always_comb
	begin
		std_rise = 1'b0;
		std_fall = 1'b0;
		lat_rise = 1'b0;
		num_rise = 1'b0;
		num_zero = 1'b1;
		for (int i = 0; i < NUM_IN; i++)
		begin
			if (din_func_i[i] == FUNC_STANDARD_START &&
			    din_value_i[i] == VALUE_REQUIRED)
			begin
				std_rise = std_rise | rise[i];
				std_fall = std_fall | fall[i];
			end
			if (din_func_i[i] == FUNC_LATCHED_START &&
			    din_value_i[i] == VALUE_REQUIRED)
				lat_rise = lat_rise | rise[i];
			if (din_func_i[i] == FUNC_NUMBERED_START)
				num_rise = num_rise | rise[i];
			if (din_func_i[i] == FUNC_TASK_NUM_BIT && lvl[i])
				num_zero = 1'b0;
		end
	end

	// home and task requests from every source
	always_comb
	begin
		home_req = (num_rise & num_zero)
			| (rise[NUM_IN] & (task_number_bit_i == TASK_RESET))
			| (rise[NUM_IN+1] & (auto_home_on_enable_i == AUTO_HOME_ON));
		task_req = std_rise | lat_rise | (num_rise & ~num_zero)
			| (rise[NUM_IN] & (task_number_bit_i != TASK_RESET));
		stop_any = std_fall | terminal_stop_i | bus_stop_i;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_cur          = cur;
		next_cur.start    = 1'b0;
		next_cur.cancel   = 1'b0;
		next_cur.home     = 1'b0;
		next_cur.set_ref  = 1'b0;
		if (home_done_i)
			next_cur.homed = 1'b1;
		if (editor_open_i && cur.running)
		begin
			next_cur.cancel  = 1'b1;
			next_cur.running = 1'b0;
		end
		else if (home_req)
		begin
			if (home_method_i == HOME_METHOD_IMMED)
			begin
				next_cur.set_ref = 1'b1;
				next_cur.homed   = 1'b1;
			end
			else
				next_cur.home = 1'b1;
		end
		else if (task_req && !editor_open_i)
		begin
			if (!cur.homed)
				next_cur.err = ERR_NOT_HOMED;
			else
			begin
				next_cur.start   = 1'b1;
				next_cur.running = 1'b1;
				next_cur.err     = ERR_NONE;
				next_cur.number  = task_number_bit_i;
			end
		end
		else if (stop_any && cur.running)
		begin
			next_cur.cancel  = 1'b1;
			next_cur.running = 1'b0;
		end
	end

	// state register
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cur <= '0;
		else
			cur <= next_cur;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign task_start_o      = cur.start;
	assign task_number_o     = cur.number;
	assign task_cancel_o     = cur.cancel;
	assign home_start_o      = cur.home;
	assign set_ref_now_o     = cur.set_ref;
	assign program_running_o = cur.running;
	assign homed_o           = cur.homed;
	assign error_code_o      = cur.err;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_latch_holds: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(program_running_o && !stop_any && !editor_open_i && !home_req)
		|=> program_running_o) else $error("latched program dropped");
	a_stop_cancels: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(program_running_o && !home_req && !task_req
		&& (terminal_stop_i || bus_stop_i))
		|=> task_cancel_o && !program_running_o) else $error("stop ignored");
	a_std_fall_stop: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(program_running_o && std_fall && !home_req && !task_req)
		|=> task_cancel_o) else $error("falling edge did not cancel");
	a_editor_halts: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(editor_open_i && program_running_o)
		|=> !program_running_o) else $error("editor did not halt tasks");
	a_not_homed: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(task_req && !homed_o && !home_req && !editor_open_i
		&& !(editor_open_i && program_running_o))
		|=> error_code_o == ERR_NOT_HOMED && !task_start_o)
		else $error("unhomed task not refused");
	a_start_homed: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		task_start_o |-> $past(homed_o)) else $error("start while unhomed");
	a_immed_ref: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		set_ref_now_o |-> !home_start_o ##1 homed_o)
		else $error("immediate reference not set");
	a_home_dedic: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(rise[NUM_IN] && task_number_bit_i == TASK_RESET
		&& !(editor_open_i && program_running_o))
		|=> home_start_o || set_ref_now_o) else $error("home not started");
	a_auto_home: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(rise[NUM_IN+1] && auto_home_on_enable_i
		&& !(editor_open_i && program_running_o))
		|=> home_start_o || set_ref_now_o) else $error("auto home missed");
	a_num_home: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(num_rise && num_zero && !(editor_open_i && program_running_o))
		|=> (home_start_o || set_ref_now_o) && !task_start_o)
		else $error("numbered home missed");
	a_std_start: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(std_rise && homed_o && !home_req && !editor_open_i)
		|=> task_start_o) else $error("standard start missed");
endmodule : motion_task_start_select

//--- motion_start_pkg.sv
// Purpose: shared constants for the motion task start and select logic
// Assumes: one control clock at 250 MHz
// Notes:   input function codes match the drive configuration values
package motion_start_pkg;
	// ----------------------------------------------------------------
	// input function codes
	// ----------------------------------------------------------------
	localparam logic [7:0] FUNC_STANDARD_START = 8'h10; // value 16
	localparam logic [7:0] FUNC_NUMBERED_START = 8'h11; // value 17
	localparam logic [7:0] FUNC_LATCHED_START  = 8'h17; // value 23
	localparam logic [7:0] FUNC_TASK_NUM_BIT   = 8'h09; // value 9
	localparam logic [7:0] VALUE_REQUIRED      = 8'h00;
	localparam logic [7:0] HOME_METHOD_IMMED   = 8'h00;
	localparam logic       AUTO_HOME_ON        = 1'h1;
	localparam logic [7:0] ERR_NOT_HOMED       = 8'h09; // code n09
	localparam logic [7:0] ERR_NONE            = 8'h00;
	// ----------------------------------------------------------------
	// sizes and reset values
	// ----------------------------------------------------------------
	localparam int         NUM_IN              = 2;
	localparam int         TASK_BITS           = 8;
	localparam logic [7:0] TASK_RESET          = 8'h00;
endpackage : motion_start_pkg

//--- edge_sync.sv
// Purpose: two-stage synchroniser with rising and falling edge pulses
// Assumes: raw input is asynchronous to mclk_i
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module edge_sync
	import motion_start_pkg::*;
(
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	// raw input
	input  wire logic raw_i,
	// conditioned outputs
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic rise;
		logic fall;
	} edge_s;

	edge_s cur;
	edge_s next_cur;

	// next state: sync chain and edge compare of registered samples
	always_comb
	begin
		next_cur      = cur;
		next_cur.meta = raw_i;
		next_cur.sync = cur.meta;
		next_cur.prev = cur.sync;
		next_cur.rise = cur.sync & ~cur.prev;
		next_cur.fall = ~cur.sync & cur.prev;
	end

	// state register
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign level_o = cur.prev;
	assign rise_o  = cur.rise;
	assign fall_o  = cur.fall;

	a_rise_single: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		rise_o |=> !rise_o) else $error("rise pulse longer than one cycle");
	a_rise_cause: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(cur.sync) |=> rise_o) else $error("edge not detected");
endmodule : edge_sync

//--- home_responder.sv
// Purpose: far-side model that answers home requests with a done pulse
// Assumes: one request at a time, no request while a count runs
// Notes:   done arrives DONE_DELAY+1 cycles after the request pulse
`timescale 1ns/1ps
module home_responder
#(
	parameter int DONE_DELAY = 3
)
(
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	// requests from the start logic
	input  wire logic home_start_i,
	input  wire logic set_ref_now_i,
	// answer back
	output logic      home_done_o
);
	logic [3:0] cnt;

	// count down after a request, then one done pulse
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt         <= 4'h0;
			home_done_o <= 1'b0;
		end
		else
		begin
			home_done_o <= (cnt == 4'h1);
			if (home_start_i || set_ref_now_i)
				cnt <= 4'(DONE_DELAY);
			else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
endmodule : home_responder

//--- testbench.sv
// Purpose: self-checking bench for the motion task start and select logic
// Assumes: output pulses follow an input edge by four cycles
// Notes:   pulses are counted by a monitor and compared in batches
`timescale 1ns/1ps
module testbench;
	import motion_start_pkg::*;
	logic              mclk_i = 1'b0;
	logic              rst_n_i = 1'b0;
	logic [NUM_IN-1:0] din = '0;
	logic [7:0]        func [NUM_IN] = '{FUNC_STANDARD_START, FUNC_NUMBERED_START};
	logic [7:0]        val [NUM_IN] = '{8'h00, 8'h00};
	logic              ded = 1'b0, en = 1'b1, auto = 1'b0, done;
	logic [7:0]        tnum = 8'h00, meth = 8'h00, tn;
	logic              tstop = 1'b0, bstop = 1'b0, edit = 1'b0;
	logic              t_st, t_ca, h_st, s_ref, run, homed;
	logic [7:0]        t_no, err;
	logic [7:0]        n_st = 8'h00, n_ca = 8'h00;
	logic [7:0]        n_hm = 8'h00, n_rf = 8'h00;
	int                fails = 0, check_count = 0, cyc = 0, seed;

	motion_task_start_select motion_task_start_select_i (.mclk_i(mclk_i),
		.rst_n_i(rst_n_i), .din_i(din), .din_func_i(func), .din_value_i(val),
		.dedicated_task_start_input_i(ded), .task_number_bit_i(tnum),
		.drive_enable_i(en), .auto_home_on_enable_i(auto),
		.home_method_i(meth), .home_done_i(done), .terminal_stop_i(tstop),
		.bus_stop_i(bstop), .editor_open_i(edit), .task_start_o(t_st),
		.task_number_o(t_no), .task_cancel_o(t_ca), .home_start_o(h_st),
		.set_ref_now_o(s_ref), .program_running_o(run), .homed_o(homed),
		.error_code_o(err));
	home_responder home_responder_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.home_start_i(h_st), .set_ref_now_i(s_ref), .home_done_o(done));

	// clock and cycle ceiling
	initial forever #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			fails = fails + 1;
			end_sim();
		end
	end

	// count output pulses
	always @(posedge mclk_i)
	begin
		n_st <= n_st + 8'(t_st);
		n_ca <= n_ca + 8'(t_ca);
		n_hm <= n_hm + 8'(h_st);
		n_rf <= n_rf + 8'(s_ref);
	end

	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : step

	// let outputs settle before they are compared
	task automatic look;
		@(negedge mclk_i);
	endtask : look

	task automatic chk(input string name, input logic [7:0] exp, got);
		check_count = check_count + 1;
		if (got !== exp)
		begin
			fails = fails + 1;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// main sequence
	initial
	begin
		seed = $urandom(32'hcd695b84);
		step(2);
		rst_n_i <= 1'b1;
		look();
		chk("homed", 8'h00, 8'(homed));
		step(1);
		tnum <= 8'h05;
		ded  <= 1'b1;
		step(8);
		look();
		chk("err", ERR_NOT_HOMED, err);
		chk("starts", 8'h00, n_st);
		step(1);
		ded  <= 1'b0;
		tnum <= 8'h00;
		step(4);
		ded <= 1'b1;
		step(12);
		look();
		chk("refs", 8'h01, n_rf);
		chk("homes", 8'h00, n_hm);
		chk("homed", 8'h01, 8'(homed));
		step(1);
		ded  <= 1'b0;
		meth <= 8'h01;
		step(4);
		din[1] <= 1'b1;
		step(8);
		look();
		chk("homes", 8'h01, n_hm);
		step(1);
		din[1] <= 1'b0;
		step(8);
		for (int i = 0; i < 4; i++)
		begin
			tn = (i == 0) ? 8'hff : 8'($urandom_range(254, 1));
			tnum   <= tn;
			din[0] <= 1'b1;
			step(8);
			look();
			chk("starts", 8'(i + 1), n_st);
			chk("number", tn, t_no);
			chk("err", ERR_NONE, err);
			step(1);
			din[0] <= 1'b0;
			step(8);
			look();
			chk("cancels", 8'(i + 1), n_ca);
			step(1);
		end
		func[1] <= FUNC_LATCHED_START;
		step(4);
		din[1] <= 1'b1;
		step(8);
		din[1] <= 1'b0;
		step(8);
		look();
		chk("running", 8'h01, 8'(run));
		step(1);
		din[0] <= 1'b1;
		step(8);
		din[0] <= 1'b0;
		step(8);
		look();
		chk("running", 8'h00, 8'(run));
		step(1);
		for (int k = 0; k < 3; k++)
		begin
			din[1] <= 1'b1;
			step(8);
			din[1] <= 1'b0;
			tstop  <= (k == 0);
			bstop  <= (k == 1);
			edit   <= (k == 2);
			step(3);
			look();
			chk("running", 8'h00, 8'(run));
			step(1);
			tstop <= 1'b0;
			bstop <= 1'b0;
			edit  <= 1'b0;
			step(4);
		end
		en <= 1'b0;
		step(6);
		auto <= AUTO_HOME_ON;
		en   <= 1'b1;
		step(8);
		look();
		chk("homes", 8'h02, n_hm);
		step(1);
		// numbered start with a task-number bit high starts a task
		func[0] <= FUNC_TASK_NUM_BIT;
		func[1] <= FUNC_NUMBERED_START;
		din[0]  <= 1'b1;
		step(4);
		din[1] <= 1'b1;
		step(8);
		look();
		chk("starts", 8'h0a, n_st);
		chk("homes", 8'h02, n_hm);
		step(1);
		// reset in mid-run, then a home move answered by the responder
		din  <= '0;
		tnum <= 8'h00;
		auto <= 1'b0;
		step(2);
		rst_n_i <= 1'b0;
		step(2);
		rst_n_i <= 1'b1;
		look();
		chk("homed", 8'h00, 8'(homed));
		chk("running", 8'h00, 8'(run));
		step(1);
		ded <= 1'b1;
		step(12);
		look();
		chk("homes", 8'h03, n_hm);
		chk("homed", 8'h01, 8'(homed));
		step(1);
		end_sim();
	end
endmodule : testbench
